// [iws_map.svh]
`ifndef IWS_MAP_SVH
`define IWS_MAP_SVH
// Register byte offsets on the AXI4-Lite bus
`define IWS_OFS_FLAG 8'h00
`define IWS_OFS_MASK 8'h04
`define IWS_OFS_STAT 8'h08
`define IWS_OFS_DIR 8'h0c
`define IWS_OFS_CFG 8'h10
`define IWS_OFS_PORT 8'h14
// Interrupt flag and mask bit positions
`define IWS_B_TMR 0
`define IWS_B_PCH 1
`define IWS_B_EXT 2
// Status register bit positions
`define IWS_B_T 0
`define IWS_B_P 1
`define IWS_B_GIE 2
`define IWS_B_SLP 3
// Vector addresses
`define IWS_VEC_INT 10'h008
`define IWS_VEC_SWI 10'h001
// Reset values and the pin 0 mask
`define IWS_RST_FLAGS 3'h0
`define IWS_RST_MASK 3'h0
`define IWS_RST_DIR 8'hff
`define IWS_PIN0_MASK 8'h01
// AXI responses
`define IWS_RESP_OK 2'h0
`define IWS_RESP_ERR 2'h2
`endif

// [iws_pkg.sv]
package iws_pkg;
  typedef enum logic [0:0] {
    IWS_RUN = 1'b0,
    IWS_SLEEP = 1'b1
  } iws_mode_t;

  typedef struct packed {
    logic t;
    logic p;
    iws_mode_t mode;
    logic gie;
    logic [2:0] flags;
    logic [2:0] mask;
    logic [7:0] dir;
    logic int_sel;
    logic [7:0] p6ref;
    logic tmr_d;
    logic ext_d;
    logic pin_d;
    logic core_rst;
    logic vec_take;
    logic [9:0] vec_addr;
    logic wake_cont;
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } iws_state_t;
endpackage : iws_pkg

// [iws_top.sv]
`timescale 1ns/10ps
`include "iws_map.svh"
// Summary of operation
// RL1 - Reset on power-on, pin pulse, watchdog
// RL2 - Power-on sets timeout and powerdown flags
// RL3 - Running pin reset keeps both flags
// RL4 - Pin wake from sleep: T=1, P=0
// RL5 - Running watchdog reset clears T, keeps P
// RL6 - Watchdog wake from sleep clears both
// RL7 - Port change wake: T=1, P=0
// RL8 - Clear-watchdog, sleep, expiry update flags
// RL9 - Three event sources: timer and pin falling edges, port change
// RL10 - Software reads port before enabling change
// RL11 - Only input pins detect changes
// RL12 - Enabled port change wakes from sleep
// RL13 - Wake continues, or vectors if enabled
// RL14 - Flags latch, mask gates, enable instructions
// RL15 - Enabled interrupt vectors to 008H
// RL16 - Software clears flag before leaving handler
// RL17 - Flags set regardless of mask, except port
// RL18 - Flag read returns flags AND mask
// RL19 - Return-from-interrupt sets global enable
// RL20 - Software interrupt vectors to 001H; the code takes it only with GIE set, awake and no interrupt pending
// RL21 - Flags stay set until software clears or a reset
module iws_top (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic RESET_N_PIN,
  input wire logic WDT_EXPIRE,
  input wire logic CLR_WDT_INSTR,
  input wire logic SLEEP_INSTR,
  input wire logic GIE_SET_INSTR,
  input wire logic GIE_CLR_INSTR,
  input wire logic RETURN_INSTR,
  input wire logic SWI_INSTR,
  input wire logic TIMER_OVF,
  input wire logic EXT_INT_N,
  input wire logic [7:0] PORT6_IN,
  output logic CORE_RESET,
  output logic SLEEPING,
  output logic VEC_TAKE,
  output logic [9:0] VEC_ADDR,
  output logic WAKE_CONT,
  output logic TIMEOUT_FLAG,
  output logic POWERDOWN_FLAG,
  output logic GIE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2:0] iws_unused_tie
);
  import iws_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Pins that may raise a change event
  function automatic logic [7:0] watch_pins(
    input logic [7:0] dir,
    input logic int_sel
  );
    logic [7:0] w;
    w = ~dir;
    if (int_sel) begin
      w = w & ~`IWS_PIN0_MASK;
    end
    return w;
  endfunction : watch_pins

  // True when the offset names a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `IWS_OFS_FLAG) || (a == `IWS_OFS_MASK) ||
           (a == `IWS_OFS_STAT) || (a == `IWS_OFS_DIR) ||
           (a == `IWS_OFS_CFG) || (a == `IWS_OFS_PORT);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////
  // State and event terms

  iws_state_t st;
  iws_state_t next_st;
  logic pin_rise;
  logic [7:0] watched;
  logic port_chg;
  logic [2:0] events;
  logic [2:0] pending;
  logic wake_evt;
  logic do_write;
  logic do_read;
  logic [2:0] wclr;
  logic sleeping_now;

  assign sleeping_now = (st.mode == IWS_SLEEP);
  // Pin reset takes effect on the rising edge ending the low pulse
  assign pin_rise = RESET_N_PIN && !st.pin_d;
  assign watched = watch_pins(st.dir, st.int_sel);
  // RL11 input pins only
  assign port_chg = |((PORT6_IN ^ st.p6ref) & watched);
  // RL9 falling edges of timer and pin; port event is any watched-pin change
  assign events[`IWS_B_TMR] = st.tmr_d && !TIMER_OVF;
  assign events[`IWS_B_EXT] = st.int_sel && st.ext_d && !EXT_INT_N;
  // RL17 port change obeys its mask, others do not
  assign events[`IWS_B_PCH] = port_chg && st.mask[`IWS_B_PCH];
  assign pending = st.flags & st.mask;
  // RL12 enabled port change wakes the core
  assign wake_evt = sleeping_now && events[`IWS_B_PCH];
  assign do_write = st.aw_ok && st.w_ok && !st.bvalid;
  assign do_read = S_AXI_ARVALID && !st.rvalid;
  // Write-one-to-clear on the flag register
  assign wclr = (do_write && st.wstrb0 && st.awaddr == `IWS_OFS_FLAG) ?
                st.wdata[2:0] : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.core_rst = 1'b0;
    next_st.vec_take = 1'b0;
    next_st.wake_cont = 1'b0;
    next_st.tmr_d = TIMER_OVF;
    next_st.ext_d = EXT_INT_N;
    next_st.pin_d = RESET_N_PIN;

    // RL21 flags clear by software or pin/watchdog/power-on reset; RL14 latch
    next_st.flags = (st.flags & ~wclr) | events;

    // Reference follows any detected change
    if (port_chg) begin
      next_st.p6ref = PORT6_IN;
    end

    // Global enable instructions
    // RL14 enable and disable
    if (GIE_SET_INSTR) begin
      next_st.gie = 1'b1;
    end
    if (GIE_CLR_INSTR) begin
      next_st.gie = 1'b0;
    end
    // RL19 return sets global enable
    if (RETURN_INSTR) begin
      next_st.gie = 1'b1;
    end

    // RL8 instruction effects on status flags
    if (CLR_WDT_INSTR) begin
      next_st.t = 1'b1;
      next_st.p = 1'b1;
    end
    if (SLEEP_INSTR && !sleeping_now) begin
      next_st.t = 1'b1;
      next_st.p = 1'b0;
      next_st.mode = IWS_SLEEP;
    end

    // Vectoring; entry drops the enable to stop re-entry
    if (wake_evt) begin
      // RL7 change wake flags
      next_st.t = 1'b1;
      next_st.p = 1'b0;
      next_st.mode = IWS_RUN;
      // RL13 continue or vector
      if (st.gie) begin
        next_st.vec_take = 1'b1;
        next_st.vec_addr = `IWS_VEC_INT;
        next_st.gie = 1'b0;
      end else begin
        next_st.wake_cont = 1'b1;
      end
    end else if (!sleeping_now && st.gie && |pending) begin
      // RL15 vector to 008H
      next_st.vec_take = 1'b1;
      next_st.vec_addr = `IWS_VEC_INT;
      next_st.gie = 1'b0;
    end else if (!sleeping_now && st.gie && SWI_INSTR) begin
      // RL20 software vector 001H
      next_st.vec_take = 1'b1;
      next_st.vec_addr = `IWS_VEC_SWI;
      next_st.gie = 1'b0;
    end

    // AXI write channel capture
    if (S_AXI_AWVALID && !st.aw_ok) begin
      next_st.aw_ok = 1'b1;
      next_st.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st.w_ok) begin
      next_st.w_ok = 1'b1;
      next_st.wdata = S_AXI_WDATA[7:0];
      next_st.wstrb0 = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = is_mapped(st.awaddr) ? `IWS_RESP_OK : `IWS_RESP_ERR;
      if (st.wstrb0) begin
        case (st.awaddr)
          `IWS_OFS_MASK: begin
            next_st.mask = st.wdata[2:0];
          end
          `IWS_OFS_DIR: begin
            next_st.dir = st.wdata;
          end
          `IWS_OFS_CFG: begin
            next_st.int_sel = st.wdata[0];
          end
          default: begin
            next_st.dir = next_st.dir;
          end
        endcase
      end
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // AXI read channel
    if (do_read) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = is_mapped(S_AXI_ARADDR) ? `IWS_RESP_OK :
                      `IWS_RESP_ERR;
      case (S_AXI_ARADDR)
        `IWS_OFS_FLAG: begin
          // RL18 flags AND mask
          next_st.rdata = {5'h00, pending};
        end
        `IWS_OFS_MASK: begin
          next_st.rdata = {5'h00, st.mask};
        end
        `IWS_OFS_STAT: begin
          next_st.rdata = {4'h0, sleeping_now, st.gie, st.p, st.t};
        end
        `IWS_OFS_DIR: begin
          next_st.rdata = st.dir;
        end
        `IWS_OFS_CFG: begin
          next_st.rdata = {7'h00, st.int_sel};
        end
        `IWS_OFS_PORT: begin
          // RL10 reading the port arms the detector
          next_st.rdata = PORT6_IN;
          next_st.p6ref = PORT6_IN;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
    if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end

    // Pin or watchdog reset; the bus side stays alive
    // RL1 reset causes
    if (WDT_EXPIRE || pin_rise) begin
      next_st.core_rst = 1'b1;
      next_st.flags = `IWS_RST_FLAGS;
      next_st.mask = `IWS_RST_MASK;
      next_st.gie = 1'b0;
      next_st.vec_take = 1'b0;
      next_st.wake_cont = 1'b0;
      next_st.mode = IWS_RUN;
      next_st.t = st.t;
      next_st.p = st.p;
      if (WDT_EXPIRE) begin
        // RL5 running: clear T, keep P
        next_st.t = 1'b0;
        // RL6 sleeping: clear both
        if (sleeping_now) begin
          next_st.p = 1'b0;
        end
      end else if (sleeping_now) begin
        // RL4 pin wake flags
        next_st.t = 1'b1;
        next_st.p = 1'b0;
      end
      // RL3 running pin reset keeps both flags
    end

    // Power-on reset has the last word
    if (SRST) begin
      next_st = '0;
      // RL2 power-on sets both
      next_st.t = 1'b1;
      next_st.p = 1'b1;
      next_st.mode = IWS_RUN;
      next_st.flags = `IWS_RST_FLAGS;
      next_st.mask = `IWS_RST_MASK;
      next_st.dir = `IWS_RST_DIR;
      next_st.tmr_d = 1'b0;
      next_st.ext_d = 1'b1;
      next_st.pin_d = 1'b1;
      next_st.core_rst = 1'b1;
    end
  end

  // Single state register
  always_ff @(posedge MCLK) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register
  assign CORE_RESET = st.core_rst;
  assign SLEEPING = sleeping_now;
  assign VEC_TAKE = st.vec_take;
  assign VEC_ADDR = st.vec_addr;
  assign WAKE_CONT = st.wake_cont;
  assign TIMEOUT_FLAG = st.t;
  assign POWERDOWN_FLAG = st.p;
  assign GIE = st.gie;
  assign S_AXI_AWREADY = !st.aw_ok;
  assign S_AXI_WREADY = !st.w_ok;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = !st.rvalid;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = {24'h000000, st.rdata};
  assign S_AXI_RRESP = st.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  logic quiet;
  assign quiet = !WDT_EXPIRE && !pin_rise;

  // RL2 power-on values
  por_flags_a: assert property ( // RL2
    $past(SRST) |-> TIMEOUT_FLAG && POWERDOWN_FLAG && CORE_RESET)
    else $error("power-on flags wrong");

  // RL3 running pin reset
  pin_keep_a: assert property ( // RL3
    pin_rise && !WDT_EXPIRE && !SLEEPING |=>
    $stable(TIMEOUT_FLAG) && $stable(POWERDOWN_FLAG) && CORE_RESET)
    else $error("running pin reset changed flags");

  // RL4 pin wake
  pin_wake_a: assert property ( // RL4
    pin_rise && !WDT_EXPIRE && SLEEPING |=>
    TIMEOUT_FLAG && !POWERDOWN_FLAG && !SLEEPING)
    else $error("pin wake flags wrong");

  // RL5 and RL6 watchdog expiry
  wdt_flags_a: assert property ( // RL5
    WDT_EXPIRE |=> !TIMEOUT_FLAG && CORE_RESET &&
    (POWERDOWN_FLAG == ($past(POWERDOWN_FLAG) && !$past(SLEEPING))))
    else $error("watchdog flags wrong");

  // RL7 and RL13 port wake
  port_wake_a: assert property ( // RL7
    wake_evt && quiet |=> TIMEOUT_FLAG && !POWERDOWN_FLAG &&
    (VEC_TAKE == $past(st.gie)) && (WAKE_CONT != $past(st.gie)))
    else $error("port wake wrong");

  // RL8 sleep instruction
  sleep_instr_a: assert property ( // RL8
    SLEEP_INSTR && !SLEEPING && quiet && !CLR_WDT_INSTR |=>
    SLEEPING && TIMEOUT_FLAG && !POWERDOWN_FLAG)
    else $error("sleep entry wrong");

  // RL15 interrupt vector
  vec_int_a: assert property ( // RL15
    st.gie && |pending && !SLEEPING && quiet |=>
    VEC_TAKE && VEC_ADDR == `IWS_VEC_INT && !GIE)
    else $error("interrupt vector wrong");

  // RL20 software vector
  vec_swi_a: assert property ( // RL20
    st.gie && SWI_INSTR && !(|pending) && !SLEEPING && quiet |=>
    VEC_TAKE && VEC_ADDR == `IWS_VEC_SWI)
    else $error("software vector wrong");

  // RL21 flags persist without a clear
  flag_hold_a: assert property ( // RL21
    |st.flags && wclr == 3'h0 && quiet |=>
    (st.flags & $past(st.flags)) == $past(st.flags))
    else $error("flag dropped by hardware");

  // RL18 masked read
  read_mask_a: assert property ( // RL18
    do_read && S_AXI_ARADDR == `IWS_OFS_FLAG |=>
    S_AXI_RDATA[2:0] == ($past(st.flags) & $past(st.mask)))
    else $error("flag read not masked");

  // RL19 return enables
  ret_gie_a: assert property ( // RL19
    RETURN_INSTR && !GIE_CLR_INSTR && quiet |=> GIE)
    else $error("return did not enable");

  wake_vec_c: cover property (wake_evt && st.gie ##1 VEC_TAKE);
  wake_cont_c: cover property (wake_evt && !st.gie ##1 WAKE_CONT);
  wdt_sleep_c: cover property (WDT_EXPIRE && SLEEPING);
  axi_write_c: cover property (do_write ##1 S_AXI_BVALID);
endmodule : iws_top

// [iws_pins_model.sv]
`timescale 1ns/10ps
// Far-side pins: reset pin, interrupt pin and port 6 levels
module iws_pins_model (
  input wire logic mclk,
  input wire logic rst_req,
  input wire logic int_req,
  input wire logic [7:0] port_set,
  output logic reset_n_pin,
  output logic ext_int_n,
  output logic [7:0] port6_in
);
  logic [1:0] rst_cnt = 2'h0;
  logic [1:0] int_cnt = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // high-low-high pulse
  // Low for three cycles so the closing rise is one clean edge
  always_ff @(posedge mclk) begin
    if (rst_req) begin
      rst_cnt <= 2'h3;
    end else if (rst_cnt != 2'h0) begin
      rst_cnt <= rst_cnt - 2'h1;
    end
  end
  assign reset_n_pin = (rst_cnt == 2'h0);

  always_ff @(posedge mclk) begin
    if (int_req) begin
      int_cnt <= 2'h2;
    end else if (int_cnt != 2'h0) begin
      int_cnt <= int_cnt - 2'h1;
    end
  end
  assign ext_int_n = (int_cnt == 2'h0);

  // Port levels follow the bench directly
  assign port6_in = port_set;
endmodule : iws_pins_model

// [iws_top_tb.sv]
`timescale 1ns/10ps
`include "iws_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module iws_top_tb;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [6:0] ev = 7'h00; // wdt,swi,ret,gie_clr,gie_set,sleep,clr_wdt
  logic tmr = 1'b0;
  logic rst_req = 1'b0;
  logic int_req = 1'b0;
  logic [7:0] port_set = 8'h00;
  logic rst_n, ext_n, core_rst, sleeping, vec_take, wake_cont;
  logic t_flag, p_flag, gie, awready, wready, bvalid, arready, rvalid;
  logic [7:0] port6, rd;
  logic [23:0] hi;
  logic [9:0] vec_addr;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [1:0] bresp, rresp, rsp;
  logic [2:0] pulses;
  logic seen;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, instances and hang guard
  initial begin
    forever #5 mclk = ~mclk;
  end
  iws_top iws_top_inst (.MCLK(mclk), .SRST(srst), .RESET_N_PIN(rst_n),
    .WDT_EXPIRE(ev[6]), .CLR_WDT_INSTR(ev[0]), .SLEEP_INSTR(ev[1]),
    .GIE_SET_INSTR(ev[2]), .GIE_CLR_INSTR(ev[3]), .RETURN_INSTR(ev[4]),
    .SWI_INSTR(ev[5]), .TIMER_OVF(tmr), .EXT_INT_N(ext_n),
    .PORT6_IN(port6), .CORE_RESET(core_rst), .SLEEPING(sleeping),
    .VEC_TAKE(vec_take), .VEC_ADDR(vec_addr), .WAKE_CONT(wake_cont),
    .TIMEOUT_FLAG(t_flag), .POWERDOWN_FLAG(p_flag), .GIE(gie),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .iws_unused_tie(3'h0));
  iws_pins_model iws_pins_model_inst (.mclk(mclk), .rst_req(rst_req),
    .int_req(int_req), .port_set(port_set), .reset_n_pin(rst_n),
    .ext_int_n(ext_n), .port6_in(port6));
  assign pulses = {core_rst, wake_cont, vec_take};
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus and stimulus helpers; handshakes judged at the rising edge
  task axi_wr(input logic [7:0] a, input logic [7:0] d);
    logic b_hs;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(posedge mclk);
      b_hs = bvalid;
      rsp = bresp;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a);
    logic r_hs;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(posedge mclk);
      r_hs = rvalid;
      rd = rdata[7:0];
      hi = rdata[31:8];
      rsp = rresp;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
  endtask : axi_rd

  task op(input logic [6:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 7'h00;
    #1;
  endtask : op

  task pin(input logic rst);
    @(posedge mclk);
    if (rst) rst_req <= 1'b1;
    else int_req <= 1'b1;
    @(posedge mclk);
    rst_req <= 1'b0;
    int_req <= 1'b0;
  endtask : pin

  // Pulses stand one cycle, so look once in every cycle
  task wait_out(input int sel);
    seen = 1'b0;
    #1;
    repeat (10) begin
      if (pulses[sel] === 1'b1) seen = 1'b1;
      @(posedge mclk);
      #1;
    end
  endtask : wait_out

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    `CHK("timeout flag", 1'b1, t_flag)
    `CHK("powerdown flag", 1'b1, p_flag)
    axi_rd(`IWS_OFS_STAT);
    `CHK("status", 8'h03, rd)
    `CHK("status resp", `IWS_RESP_OK, rsp)
    `CHK("rdata upper", 24'h000000, hi)
    axi_rd(8'h40);
    `CHK("unmapped rd", 8'h00, rd)
    `CHK("unmapped rresp", `IWS_RESP_ERR, rsp)
    axi_wr(8'h40, 8'h01);
    `CHK("unmapped resp", `IWS_RESP_ERR, rsp)
  endtask : t_reset

  task t_flags;
    @(posedge mclk);
    tmr <= 1'b1;
    @(posedge mclk);
    tmr <= 1'b0;
    axi_rd(`IWS_OFS_FLAG);
    `CHK("flag masked", 8'h00, rd)
    axi_wr(`IWS_OFS_MASK, 8'h07);
    axi_rd(`IWS_OFS_FLAG);
    `CHK("flag unmasked", 8'h01, rd)
    axi_wr(`IWS_OFS_CFG, 8'h01);
    pin(1'b0);
    axi_rd(`IWS_OFS_FLAG);
    `CHK("ext flag", 8'h05, rd)
    axi_wr(`IWS_OFS_FLAG, 8'h04);
    axi_wr(`IWS_OFS_MASK, 8'h01);
    op(7'h04);
    wait_out(0);
    `CHK("vector seen", 1'b1, seen)
    `CHK("vector addr", `IWS_VEC_INT, vec_addr)
    axi_rd(`IWS_OFS_FLAG);
    `CHK("flag held", 8'h01, rd)
    axi_wr(`IWS_OFS_FLAG, 8'h01);
    op(7'h10);
    `CHK("gie on return", 1'b1, gie)
    op(7'h20);
    wait_out(0);
    `CHK("swi seen", 1'b1, seen)
    `CHK("swi addr", `IWS_VEC_SWI, vec_addr)
    op(7'h04);
    `CHK("gie set", 1'b1, gie)
    op(7'h08);
    `CHK("gie clear", 1'b0, gie)
  endtask : t_flags

  task t_tp;
    op(7'h02);
    `CHK("sleep t p", 2'b10, {t_flag, p_flag})
    op(7'h40);
    wait_out(2);
    `CHK("wdt reset", 1'b1, seen)
    `CHK("wdt wake t p", 2'b00, {t_flag, p_flag})
    op(7'h01);
    `CHK("clrwdt t p", 2'b11, {t_flag, p_flag})
    op(7'h40);
    wait_out(2);
    `CHK("wdt run t p", 2'b01, {t_flag, p_flag})
    pin(1'b1);
    wait_out(2);
    `CHK("pin reset", 1'b1, seen)
    `CHK("pin run t p", 2'b01, {t_flag, p_flag})
    op(7'h02);
    pin(1'b1);
    wait_out(2);
    `CHK("pin wake t p", 3'b100, {t_flag, p_flag, sleeping})
  endtask : t_tp

  task t_port;
    axi_wr(`IWS_OFS_DIR, 8'h0e);
    axi_rd(`IWS_OFS_PORT);
    axi_wr(`IWS_OFS_MASK, 8'h02);
    @(posedge mclk);
    port_set <= 8'h03;
    axi_rd(`IWS_OFS_FLAG);
    `CHK("output pin change", 8'h00, rd)
    op(7'h02);
    @(posedge mclk);
    port_set <= 8'h13;
    wait_out(1);
    `CHK("wake continue", 1'b1, seen)
    `CHK("port wake t p", 3'b100, {t_flag, p_flag, sleeping})
    axi_rd(`IWS_OFS_PORT);
    axi_wr(`IWS_OFS_FLAG, 8'h02);
    op(7'h04);
    op(7'h02);
    @(posedge mclk);
    port_set <= 8'h03;
    wait_out(0);
    `CHK("wake vector", 1'b1, seen)
    `CHK("wake addr", `IWS_VEC_INT, vec_addr)
  endtask : t_port

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and verdict
  task stop_test;
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_flags();
    t_tp();
    t_port();
    stop_test();
  end
endmodule : iws_top_tb
